// [hw/ums_defs.svh]
// register map, field positions and timing counts of the serial transceiver
// assumes inclusion by bare name from the design files
`ifndef UMS_DEFS_SVH
`define UMS_DEFS_SVH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define UMS_MR_OFS     8'h00
`define UMS_MAN_OFS    8'h04
`define UMS_CR_OFS     8'h08
`define UMS_SR_OFS     8'h0c
`define UMS_THR_OFS    8'h10
`define UMS_RHR_OFS    8'h14
`define UMS_NER_OFS    8'h18
`define UMS_BRG_OFS    8'h1c
// ****************************************
// field positions
// ****************************************
`define UMS_MR_W       7
`define UMS_MAN_PL_LO  0
`define UMS_MAN_PL_HI  3
`define UMS_MAN_PP_LO  8
`define UMS_MAN_PP_HI  9
`define UMS_MAN_MPOL   12
`define UMS_CR_TXEN    0
`define UMS_CR_RXEN    1
`define UMS_CR_RSTSTA  2
`define UMS_SR_TXRDY   0
`define UMS_SR_RECEIVE_READY_FLAG   1
`define UMS_SR_PARITY_ERROR_FLAG    2
`define UMS_SR_TXBUSY  3
`define UMS_THR_SYNC   8
// ****************************************
// timing in oversample ticks and bit counts
// ****************************************
`define UMS_TICK_LAST  4'hf
`define UMS_HALF       4'h8
`define UMS_MID        4'h7
`define UMS_IR_PULSE   4'h3
`define UMS_DATA_LAST  4'h7
`define UMS_SYNC_LAST  4'h2
`define UMS_GUARD_LAST 4'h1
`define UMS_GUARD_NACK 4'h2
`define UMS_RX_PAR     4'h9
`define UMS_RX_DATA_HI 4'h8
`define UMS_ERR_MAX    8'hff
`endif

// [hw/ums_pkg.sv]
// types of the serial transceiver
// assumes nothing beyond a SystemVerilog compiler
package ums_pkg;
  typedef enum logic [1:0] {UMS_MANCH, UMS_SCARD, UMS_IRDA, UMS_RSVD} ums_line_mode_t;
  typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_DELIM, TX_DATA, TX_PAR, TX_STOP, TX_GUARD} ums_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_BITS, RX_GUARD} ums_rx_st_t;
  typedef struct packed {
    logic       varsync;
    logic       sync_type_select;
    logic       single_bit_delimiter;
    logic       nack_inhibit;
    logic       inv;
    logic [1:0] mode;
  } ums_mode_t;
endpackage

// [hw/ums_usart.sv]
// serial transceiver: manchester framing, smart-card t=0, infrared rzi
// assumes an apb master on pclk and open-drain resolution of the io line outside
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "ums_defs.svh"
module ums_usart #(
  parameter int CDW = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             txd_out,
  input  wire logic        io_in,
  output logic             io_out,
  output logic             io_oe
);
  // ****************************************
  // apb access and registers
  // ****************************************
  ums_pkg::ums_mode_t      mode_reg;
  ums_pkg::ums_line_mode_t lmode;
  ums_pkg::ums_tx_st_t     tx_st;
  ums_pkg::ums_rx_st_t     rx_st;
  logic [3:0]     man_pl;
  logic [1:0]     man_pp;
  logic           man_mpol;
  logic           txen_reg, rxen_reg;
  logic [CDW-1:0] cd_reg, div_cnt;
  logic [7:0]     thr_reg, rhr_reg, err_cnt;
  logic           thr_sync, thr_vld, receive_ready_flag_reg, parity_error_flag_reg;
  logic [31:0]    rd_val;
  logic           acc, wr, rd, mapped, tick;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign rd      = acc & ~pwrite;
  assign lmode   = ums_pkg::ums_line_mode_t'(mode_reg.mode);
  assign mapped  = hit(paddr, `UMS_MR_OFS) | hit(paddr, `UMS_MAN_OFS) | hit(paddr, `UMS_CR_OFS) |
                   hit(paddr, `UMS_SR_OFS) | hit(paddr, `UMS_THR_OFS) | hit(paddr, `UMS_RHR_OFS) |
                   hit(paddr, `UMS_NER_OFS) | hit(paddr, `UMS_BRG_OFS);
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  assign io_out  = 1'b0;

  always_comb begin
    rd_val = '0;
    if (hit(paddr, `UMS_MR_OFS)) rd_val[`UMS_MR_W-1:0] = mode_reg;
    if (hit(paddr, `UMS_MAN_OFS)) begin
      rd_val[`UMS_MAN_PL_HI:`UMS_MAN_PL_LO] = man_pl;
      rd_val[`UMS_MAN_PP_HI:`UMS_MAN_PP_LO] = man_pp;
      rd_val[`UMS_MAN_MPOL] = man_mpol;
    end
    if (hit(paddr, `UMS_CR_OFS)) begin
      rd_val[`UMS_CR_TXEN] = txen_reg;
      rd_val[`UMS_CR_RXEN] = rxen_reg;
    end
    if (hit(paddr, `UMS_SR_OFS)) begin
      rd_val[`UMS_SR_TXRDY]  = ~thr_vld;
      rd_val[`UMS_SR_RECEIVE_READY_FLAG]  = receive_ready_flag_reg;
      rd_val[`UMS_SR_PARITY_ERROR_FLAG]   = parity_error_flag_reg;
      rd_val[`UMS_SR_TXBUSY] = tx_st != ums_pkg::TX_IDLE;
    end
    if (hit(paddr, `UMS_RHR_OFS)) rd_val[7:0] = rhr_reg;
    if (hit(paddr, `UMS_NER_OFS)) rd_val[7:0] = err_cnt;
    if (hit(paddr, `UMS_BRG_OFS)) rd_val[CDW-1:0] = cd_reg;
  end

  // read data captured in setup so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= '0;
    else if (psel & ~penable & ~pwrite) prdata <= rd_val;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= '0;
      man_pl   <= '0;
      man_pp   <= '0;
      man_mpol <= 1'b0;
      txen_reg <= 1'b0;
      rxen_reg <= 1'b0;
      cd_reg   <= '0;
    end else if (wr) begin
      if (hit(paddr, `UMS_MR_OFS)) mode_reg <= pwdata[`UMS_MR_W-1:0];
      if (hit(paddr, `UMS_MAN_OFS)) begin
        man_pl   <= pwdata[`UMS_MAN_PL_HI:`UMS_MAN_PL_LO];
        man_pp   <= pwdata[`UMS_MAN_PP_HI:`UMS_MAN_PP_LO];
        man_mpol <= pwdata[`UMS_MAN_MPOL];
      end
      if (hit(paddr, `UMS_CR_OFS)) begin
        txen_reg <= pwdata[`UMS_CR_TXEN];
        rxen_reg <= pwdata[`UMS_CR_RXEN];
      end
      if (hit(paddr, `UMS_BRG_OFS)) cd_reg <= pwdata[CDW-1:0];
    end
  end

  // ****************************************
  // oversample tick: sixteen per bit time
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_cnt <= '0;
    else if (cd_reg == '0 || tick) div_cnt <= '0;
    else div_cnt <= div_cnt + 1'b1;
  end
  assign tick = (cd_reg != '0) && (div_cnt == cd_reg - 1'b1);

  // ****************************************
  // transmitter
  // ****************************************
  logic [3:0] sub, tbit, tlast;
  logic [7:0] tsh;
  logic       tsync, tpar, nack_seen, start, bit_end, line_lv, tx_drv, cmd_lv, rx_nack;

  function automatic logic pre_bit(input logic [1:0] pp, input logic [3:0] i);
    case (pp)
      2'h0:    return 1'b1;
      2'h1:    return 1'b0;
      2'h2:    return ~i[0];
      default: return i[0];
    endcase
  endfunction

  function automatic logic mb(input logic b, input logic pol, input logic [3:0] s);
    return (s < `UMS_HALF) ? (b ^ pol) : ~(b ^ pol);
  endfunction

  assign start   = (tx_st == ums_pkg::TX_IDLE) && tick && thr_vld && txen_reg && lmode != ums_pkg::UMS_RSVD;
  assign bit_end = tick && (sub == `UMS_TICK_LAST);
  assign cmd_lv  = (tbit == 4'h0) || (tbit == 4'h1 && sub < `UMS_HALF);

  always_comb begin
    unique case (tx_st)
      ums_pkg::TX_PRE:   tlast = man_pl - 4'h1;
      ums_pkg::TX_DELIM: tlast = (lmode == ums_pkg::UMS_MANCH && !mode_reg.single_bit_delimiter) ? `UMS_SYNC_LAST : 4'h0;
      ums_pkg::TX_DATA:  tlast = `UMS_DATA_LAST;
      ums_pkg::TX_GUARD: tlast = nack_seen ? `UMS_GUARD_NACK : `UMS_GUARD_LAST;
      default:           tlast = 4'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st <= ums_pkg::TX_IDLE;
      sub   <= '0;
      tbit  <= '0;
      tsh   <= '0;
      tsync <= 1'b0;
      tpar  <= 1'b0;
    end else if (start) begin
      tx_st <= (lmode == ums_pkg::UMS_MANCH && man_pl != 4'h0) ? ums_pkg::TX_PRE : ums_pkg::TX_DELIM;
      sub   <= '0;
      tbit  <= '0;
      tsh   <= thr_reg;
      tsync <= mode_reg.varsync ? thr_sync : mode_reg.sync_type_select;
      tpar  <= ^(thr_reg ^ {8{mode_reg.inv}});
    end else if (tick && tx_st != ums_pkg::TX_IDLE) begin
      sub <= sub + 4'h1;
      if (bit_end) begin
        tbit <= (tbit == tlast) ? 4'h0 : tbit + 4'h1;
        if (tx_st == ums_pkg::TX_DATA) tsh <= tsh >> 1;
        if (tbit == tlast) begin
          unique case (tx_st)
            ums_pkg::TX_PRE:   tx_st <= ums_pkg::TX_DELIM;
            ums_pkg::TX_DELIM: tx_st <= ums_pkg::TX_DATA;
            ums_pkg::TX_DATA:  tx_st <= (lmode == ums_pkg::UMS_MANCH) ? ums_pkg::TX_IDLE :
                                        (lmode == ums_pkg::UMS_SCARD) ? ums_pkg::TX_PAR : ums_pkg::TX_STOP;
            ums_pkg::TX_PAR:   tx_st <= ums_pkg::TX_GUARD;
            default:           tx_st <= ums_pkg::TX_IDLE;
          endcase
        end
      end
    end
  end

  // guard sampled mid first bit: a nack stretches the character by one bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) nack_seen <= 1'b0;
    else if (start) nack_seen <= 1'b0;
    else if (tx_st == ums_pkg::TX_GUARD && tick && sub == `UMS_MID && tbit == 4'h0 && !io_in) nack_seen <= 1'b1;
  end

  always_comb begin
    line_lv = 1'b1;
    unique case (tx_st)
      ums_pkg::TX_PRE:   line_lv = mb(pre_bit(man_pp, tbit), man_mpol, sub);
      ums_pkg::TX_DELIM:
        if (lmode != ums_pkg::UMS_MANCH) line_lv = 1'b0;
        else if (mode_reg.single_bit_delimiter) line_lv = mb(1'b0, man_mpol, sub);
        else line_lv = tsync ? cmd_lv : ~cmd_lv;
      ums_pkg::TX_DATA:
        if (lmode == ums_pkg::UMS_MANCH) line_lv = mb(tsh[0], man_mpol, sub);
        else if (lmode == ums_pkg::UMS_SCARD) line_lv = tsh[0] ^ mode_reg.inv;
        else line_lv = tsh[0];
      ums_pkg::TX_PAR:   line_lv = tpar;
      default:           line_lv = 1'b1;
    endcase
  end

  assign tx_drv = (lmode == ums_pkg::UMS_SCARD) && !line_lv;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_out <= 1'b1;
      io_oe   <= 1'b0;
    end else begin
      if (lmode == ums_pkg::UMS_IRDA) txd_out <= !line_lv && sub < `UMS_IR_PULSE;
      else txd_out <= (lmode == ums_pkg::UMS_SCARD) ? 1'b1 : line_lv;
      io_oe <= tx_drv | rx_nack;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_reg  <= '0;
      thr_sync <= 1'b0;
      thr_vld  <= 1'b0;
    end else if (wr && hit(paddr, `UMS_THR_OFS)) begin
      thr_reg  <= pwdata[7:0];
      thr_sync <= pwdata[`UMS_THR_SYNC];
      thr_vld  <= 1'b1;
    end else if (start) thr_vld <= 1'b0;
  end

  // ****************************************
  // smart-card receiver
  // ****************************************
  logic [3:0] rsub, rbit;
  logic [7:0] rsh;
  logic       rpar, rerr, ev, perr, store, ner_rd;

  assign ev      = (rx_st == ums_pkg::RX_BITS) && tick && rsub == `UMS_MID && rbit == `UMS_RX_PAR;
  assign perr    = rpar ^ io_in;
  assign store   = ev && (!perr || mode_reg.nack_inhibit);
  assign rx_nack = (rx_st == ums_pkg::RX_GUARD) && rbit == 4'h0 && rerr;
  assign ner_rd  = rd && hit(paddr, `UMS_NER_OFS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st <= ums_pkg::RX_IDLE;
      rsub  <= '0;
      rbit  <= '0;
      rsh   <= '0;
      rpar  <= 1'b0;
      rerr  <= 1'b0;
    end else if (tick) begin
      unique case (rx_st)
        ums_pkg::RX_IDLE:
          if (rxen_reg && lmode == ums_pkg::UMS_SCARD && !io_in) begin
            rx_st <= ums_pkg::RX_BITS;
            rsub  <= '0;
            rbit  <= '0;
            rpar  <= 1'b0;
            rerr  <= 1'b0;
          end
        ums_pkg::RX_BITS: begin
          rsub <= rsub + 4'h1;
          if (rsub == `UMS_MID && rbit != 4'h0) begin
            rpar <= rpar ^ io_in;
            if (rbit <= `UMS_RX_DATA_HI) rsh <= {io_in ^ mode_reg.inv, rsh[7:1]};
          end
          if (ev) rerr <= perr && !mode_reg.nack_inhibit;
          if (rsub == `UMS_TICK_LAST) begin
            rbit <= (rbit == `UMS_RX_PAR) ? 4'h0 : rbit + 4'h1;
            if (rbit == `UMS_RX_PAR) rx_st <= ums_pkg::RX_GUARD;
          end
        end
        ums_pkg::RX_GUARD: begin
          rsub <= rsub + 4'h1;
          if (rsub == `UMS_TICK_LAST) begin
            rbit <= rbit + 4'h1;
            if (rbit == `UMS_GUARD_LAST) rx_st <= ums_pkg::RX_IDLE;
          end
        end
        default: rx_st <= ums_pkg::RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rhr_reg <= '0;
    else if (store) rhr_reg <= rsh;
  end

  // set wins over read or write clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) receive_ready_flag_reg <= 1'b0;
    else if (store) receive_ready_flag_reg <= 1'b1;
    else if (rd && hit(paddr, `UMS_RHR_OFS)) receive_ready_flag_reg <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) parity_error_flag_reg <= 1'b0;
    else if (ev && perr && !mode_reg.nack_inhibit) parity_error_flag_reg <= 1'b1;
    else if (wr && hit(paddr, `UMS_CR_OFS) && pwdata[`UMS_CR_RSTSTA]) parity_error_flag_reg <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) err_cnt <= '0;
    else if (ner_rd) err_cnt <= {7'h00, ev && perr};
    else if (ev && perr && err_cnt != `UMS_ERR_MAX) err_cnt <= err_cnt + 8'h01;
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pre_len: assert property (tx_st == ums_pkg::TX_PRE |-> man_pl != 4'h0) else $error("preamble with zero length");
  a_pre_ones: assert property (tx_st == ums_pkg::TX_PRE && man_pp == 2'h0 && sub < `UMS_HALF |-> line_lv == !man_mpol)
    else $error("all-ones preamble wrong");
  a_man_pol: assert property (tx_st == ums_pkg::TX_DATA && lmode == ums_pkg::UMS_MANCH && !man_mpol && sub >= `UMS_HALF
    |-> line_lv != tsh[0]) else $error("manchester second half wrong");
  a_single_bit_delimiter_zero: assert property (tx_st == ums_pkg::TX_DELIM && lmode == ums_pkg::UMS_MANCH && mode_reg.single_bit_delimiter
    && !man_mpol |-> line_lv == (sub >= `UMS_HALF)) else $error("delimiter not a zero");
  a_sync_cmd: assert property (tx_st == ums_pkg::TX_DELIM && lmode == ums_pkg::UMS_MANCH && !mode_reg.single_bit_delimiter && tsync
    |-> line_lv == (tbit == 4'h0 || (tbit == 4'h1 && sub < `UMS_HALF))) else $error("command sync shape");
  a_sync_data: assert property (tx_st == ums_pkg::TX_DELIM && lmode == ums_pkg::UMS_MANCH && !mode_reg.single_bit_delimiter && !tsync
    && tbit == 4'h2 |-> line_lv) else $error("data sync tail not high");
  a_sync_src: assert property (start && mode_reg.varsync |=> tsync == $past(thr_sync)) else $error("sync type source");
  a_guard_rel: assert property (tx_st == ums_pkg::TX_GUARD |-> !tx_drv) else $error("guard driven");
  a_nack_inh: assert property (rx_nack |-> !mode_reg.nack_inhibit ##1 io_oe) else $error("nack under inhibit");
  a_parity_error_flag_drop: assert property (ev && perr && !mode_reg.nack_inhibit |=> rhr_reg == $past(rhr_reg) && parity_error_flag_reg)
    else $error("errored char stored");
  a_err_sat: assert property (err_cnt == `UMS_ERR_MAX && !ner_rd |=> err_cnt == `UMS_ERR_MAX)
    else $error("error count wrapped");
  a_ir_pulse: assert property (lmode == ums_pkg::UMS_IRDA && tx_st == ums_pkg::TX_DELIM && tick && sub == 4'h0
    |=> txd_out [*1] ##0 !line_lv) else $error("infrared pulse missing");

endmodule // ums_usart

// [tb/ums_card.sv]
// smart-card model on the open-drain io line: sends and receives t=0 characters
// assumes the bench resolves the line with a pull-up and one tick per pclk cycle
`timescale 1ns/10ps
// ****************************************
// card model
// ****************************************
module ums_card #(
  parameter int BT = 16
) (
  input  wire logic pclk,
  input  wire logic io,
  output logic      pull
);
  initial pull = 1'b0;

  // one character out, bad parity on request, then watch the guard
  task automatic send(input logic [7:0] b, input logic bad, output logic nack);
    logic [9:0] f;
    f = {(^b) ^ bad, b, 1'b0};
    @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      pull <= ~f[i];
      repeat (BT) @(posedge pclk);
    end
    pull <= 1'b0;
    repeat (BT / 2) @(posedge pclk);
    nack = ~io;
    repeat (BT * 3) @(posedge pclk);
  endtask

  // one character in, sampled mid-bit
  task automatic recv(output logic [7:0] b, output logic par, output logic guard);
    while (io !== 1'b0) @(posedge pclk);
    repeat (BT / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BT) @(posedge pclk);
      b[i] = io;
    end
    repeat (BT) @(posedge pclk);
    par = io;
    repeat (BT) @(posedge pclk);
    guard = io;
    repeat (BT * 2) @(posedge pclk);
  endtask
endmodule // ums_card

// [tb/tb.sv]
// self-checking bench of the serial transceiver
// assumes ums_usart and ums_card compiled before it
`timescale 1ns/10ps
// ****************************************
// bench top
// ****************************************
module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        txd_out;
  logic        io_out;
  logic        io_oe;
  logic        card_pull;
  logic        last_err;
  wire         io = !((io_oe && !io_out) || card_pull);
  int          n_fail = 0;
  int          n_tests = 0;

  always #2.5 pclk = ~pclk;

  ums_usart #(.CDW(16)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .txd_out(txd_out), .io_in(io), .io_out(io_out), .io_oe(io_oe));
  ums_card #(.BT(16)) card_u (.pclk(pclk), .io(io), .pull(card_pull));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    // one idle edge so a back-to-back call never re-raises psel in the release step
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // expected halves: prefix, data lsb first (one = high-low, both flipped by polarity), two idle halves
  task automatic man_case(input logic [31:0] mr, man, thr, input logic [7:0] pre, input int npre);
    logic [63:0] e;
    logic [31:0] q;
    int          n;
    e = {56'h0, pre};
    n = npre + 18;
    for (int i = 0; i < 8; i++) e = {e[61:0], thr[i] ^ man[12], ~thr[i] ^ man[12]};
    e = {e[61:0], 2'b11};
    apb(1'b1, 8'h00, mr, q);
    apb(1'b1, 8'h04, man, q);
    apb(1'b1, 8'h08, 32'h1, q);
    apb(1'b1, 8'h10, thr, q);
    while (txd_out !== 1'b0) @(posedge pclk);
    repeat (4) @(posedge pclk);
    for (int i = n - 1; i >= 0; i--) begin
      chk({31'h0, txd_out}, {31'h0, e[i]});
      repeat (8) @(posedge pclk);
    end
  endtask

  task automatic sc_tx(input logic [31:0] mr, input logic [7:0] d, input logic [7:0] line);
    logic [31:0] q;
    logic [7:0]  b;
    logic        p;
    logic        g;
    apb(1'b1, 8'h00, mr, q);
    apb(1'b1, 8'h08, 32'h1, q);
    apb(1'b1, 8'h10, {24'h0, d}, q);
    card_u.recv(b, p, g);
    chk({24'h0, b}, {24'h0, line});
    chk({31'h0, p}, {31'h0, ^line});
    chk({31'h0, g}, 32'h1);
  endtask

  // card sends; expect nack, status bits [2:1], holding data, error count
  task automatic sc_rx(input logic [31:0] mr, input logic [7:0] d, input logic bad, input logic nk,
                       input logic [1:0] st, input logic [31:0] cnt);
    logic [31:0] q;
    logic        nack;
    apb(1'b1, 8'h00, mr, q);
    apb(1'b1, 8'h08, 32'h6, q);
    card_u.send(d, bad, nack);
    chk({31'h0, nack}, {31'h0, nk});
    apb(1'b0, 8'h0c, 32'h0, q);
    chk({30'h0, q[2:1]}, {30'h0, st});
    if (st[0]) begin
      apb(1'b0, 8'h14, 32'h0, q);
      chk(q & 32'hff, {24'h0, d});
    end
    apb(1'b0, 8'h18, 32'h0, q);
    chk(q, cnt);
    apb(1'b0, 8'h18, 32'h0, q);
    chk(q, 32'h0);
  endtask

  task automatic ir_case(input logic [7:0] d, input int pulses);
    logic [31:0] q;
    int          hi;
    hi = 0;
    apb(1'b1, 8'h00, 32'h2, q);
    apb(1'b1, 8'h08, 32'h1, q);
    apb(1'b1, 8'h10, {24'h0, d}, q);
    repeat (220) begin
      @(posedge pclk);
      if (txd_out === 1'b1) hi++;
    end
    chk(hi, pulses * 3);
    apb(1'b1, 8'h08, 32'h2, q);
    chk({31'h0, txd_out}, 32'h0);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    print_verdict;
  end

  initial begin
    logic [31:0] q;
    repeat (5) @(posedge pclk);
    chk({30'h0, txd_out, io_oe}, 32'h2);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h20, 32'h0, q);
    chk({31'h0, last_err}, 32'h1);
    chk(q, 32'h0);
    apb(1'b1, 8'h1c, 32'h1, q);
    man_case(32'h10, 32'h101, 32'ha5, 8'h05, 4);
    man_case(32'h10, 32'h302, 32'h3c, 8'h19, 6);
    man_case(32'h60, 32'h000, 32'h0c3, 8'h07, 6);
    man_case(32'h20, 32'h000, 32'h081, 8'h00, 3);
    man_case(32'h10, 32'h1002, 32'h55, 8'h16, 6);
    sc_tx(32'h01, 8'h03, 8'h03);
    sc_tx(32'h05, 8'h03, 8'hfc);
    sc_rx(32'h01, 8'h5a, 1'b0, 1'b0, 2'b01, 32'h0);
    sc_rx(32'h01, 8'h33, 1'b1, 1'b1, 2'b10, 32'h1);
    sc_rx(32'h09, 8'h66, 1'b1, 1'b0, 2'b01, 32'h1);
    ir_case(8'h0f, 5);
    print_verdict;
  end
endmodule // tb
